// File: rtl/mdp_pkg.sv
// Constants shared by the multi-port digital I/O block.
// Assumes a byte-addressed Avalon-MM bus, 32-bit data, one register a word.
package mdp_pkg;

  // Register byte addresses
  localparam logic [6:0] ADR_P0   = 7'h00;
  localparam logic [6:0] ADR_P2   = 7'h04;
  localparam logic [6:0] ADR_P4   = 7'h08;
  localparam logic [6:0] ADR_P5   = 7'h0c;
  localparam logic [6:0] ADR_P6   = 7'h10;
  localparam logic [6:0] ADR_P8   = 7'h14;
  localparam logic [6:0] ADR_P9   = 7'h18;
  localparam logic [6:0] ADR_PM0  = 7'h20;
  localparam logic [6:0] ADR_PM2  = 7'h24;
  localparam logic [6:0] ADR_PM4  = 7'h28;
  localparam logic [6:0] ADR_PM5  = 7'h2c;
  localparam logic [6:0] ADR_PM8  = 7'h30;
  localparam logic [6:0] ADR_PM9  = 7'h34;
  localparam logic [6:0] ADR_PU0  = 7'h40;
  localparam logic [6:0] ADR_PU1  = 7'h44;
  localparam logic [6:0] ADR_PU2  = 7'h48;
  localparam logic [6:0] ADR_CMP  = 7'h4c;

  // Field positions and implemented-bit masks
  localparam int         PU0_P0_BIT = 0;
  localparam int         PU0_P4_BIT = 4;
  localparam int         PU2_P8_LSB = 0;
  localparam int         PU2_P9_LSB = 4;
  localparam int         CMP_OD_BIT = 1;
  localparam logic [7:0] PU0_MASK   = 8'h11;
  localparam logic [7:0] PU2_MASK   = 8'h3f;

  // Reset values: direction all ones selects input everywhere
  localparam logic [7:0] DIR_RST    = 8'hff;
  localparam logic [7:0] LAT_RST    = 8'h00;
  localparam logic [7:0] PU_RST     = 8'h00;

  // Pin counts per port
  localparam int W_P0 = 4;
  localparam int W_P2 = 8;
  localparam int W_P4 = 8;
  localparam int W_P5 = 4;
  localparam int W_P6 = 7;
  localparam int W_P8 = 8;
  localparam int W_P9 = 4;

  // One control bit widened onto a pair of pins
  function automatic logic [7:0] mdp_pair(input logic [3:0] c);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      r[2*i]   = c[i];
      r[2*i+1] = c[i];
    end
    return r;
  endfunction

endpackage

// File: rtl/mdp_bus.sv
// Avalon-MM handshake for the port registers.
// Assumes the master holds its request until it sees waitrequest low.
module mdp_bus
  import mdp_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic read,
  input  wire logic write,
  output logic      waitrequest,
  output logic      rd_take,
  output logic      wr_commit
);

  // Every access answers one edge after it is seen; no refusal path
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      waitrequest <= 1'b1;
    else if ((read || write) && waitrequest)
      waitrequest <= 1'b0;
    else
      waitrequest <= 1'b1;
  end

  // Read data is captured as the request is seen, write lands at release
  assign rd_take   = read && waitrequest;
  assign wr_commit = write && !waitrequest;

endmodule

// File: rtl/mdp_port.sv
// One bidirectional port: output latch, direction bits, pad drivers.
// Assumes pin inputs already synchronous; pad outputs are registered.
module mdp_port
  import mdp_pkg::*;
#(
  parameter int W          = 8,
  parameter bit OPEN_DRAIN = 1'b0
)
(
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         wr_lat,
  input  wire logic         wr_dir,
  input  wire logic [W-1:0] wdata,
  input  wire logic [W-1:0] pin_i,
  input  wire logic [W-1:0] alt_sel,
  input  wire logic [W-1:0] alt_val,
  input  wire logic [W-1:0] od_sel,
  input  wire logic [W-1:0] pull_req,
  output logic      [W-1:0] lat_q,
  output logic      [W-1:0] dir_q,
  output logic      [W-1:0] rd_val,
  output logic      [W-1:0] pad_o,
  output logic      [W-1:0] pad_oe,
  output logic      [W-1:0] pad_pu
);

  logic [W-1:0] drv;
  logic [W-1:0] od;

  // Latch loads whatever the direction; direction resets to input
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lat_q <= LAT_RST[W-1:0];
      dir_q <= DIR_RST[W-1:0];
    end
    else
    begin
      if (wr_lat)
        lat_q <= wdata;
      if (wr_dir)
        dir_q <= wdata;
    end
  end

  // Peripheral value overrides the latch where a pin is shared
  assign drv    = (alt_sel & alt_val) | (~alt_sel & lat_q);
  assign od     = {W{OPEN_DRAIN}} | od_sel;
  assign rd_val = (dir_q & pin_i) | (~dir_q & lat_q);

  // Open-drain bits only ever pull low; pull-ups only while input
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_o  <= '0;
      pad_oe <= '0;
      pad_pu <= '0;
    end
    else
    begin
      pad_o  <= drv & ~od;
      pad_oe <= ~dir_q & (~od | ~drv);
      pad_pu <= pull_req & dir_q;
    end
  end

endmodule

// File: rtl/mdp_top.sv
// Multi-port digital I/O bank with Avalon-MM register access.
// Assumes pins synchronous to clock; pad wire resolved outside the block.
//
// What this block does
// - Port 0 has four latched pins, each with its own direction bit.
// - Port 2 has eight latched pins, each with its own direction bit.
// - Port 0 input pull-ups switch together from one bit.
// - Each port 2 input pin has its own pull-up bit.
// - After reset every pin is an input with its driver off.
// - Port 5 pins only pull low or release; direction per pin.
// - Port 5 pull-ups are a build-time choice, not software.
// - Forty-three pins: seven input-only on port 6, thirty-six two-way.
// - Masked build gives thirty-two software pull-ups plus four fixed.
// - Reprogrammable build gives only the thirty-two software pull-ups.
// - Port 2 pins can be shared with serial, timer, interrupt functions.
// - Comparator output pin becomes open drain when its select is set.
// - Port 4 input pull-ups switch together as eight pins.
// - Ports 8 and 9 input pull-ups switch in pairs of pins.
// - Direction registers reset to all ones; writes update them.
// - A level change on a port 2 interrupt pin raises its request.
module mdp_top
  import mdp_pkg::*;
#(
  parameter bit         FLASH_BUILD = 1'b0,
  parameter logic [3:0] P5_MASK_PU  = 4'h0
)
(
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [6:0]       address,
  input  wire logic             read,
  input  wire logic             write,
  input  wire logic [3:0]       byteenable,
  input  wire logic [31:0]      writedata,
  output logic      [31:0]      readdata,
  output logic                  waitrequest,
  input  wire logic [W_P0-1:0]  p0_i,
  output logic      [W_P0-1:0]  p0_o,
  output logic      [W_P0-1:0]  p0_oe,
  output logic      [W_P0-1:0]  p0_pu,
  input  wire logic [W_P2-1:0]  p2_i,
  output logic      [W_P2-1:0]  p2_o,
  output logic      [W_P2-1:0]  p2_oe,
  output logic      [W_P2-1:0]  p2_pu,
  input  wire logic [W_P2-1:0]  p2_alt_sel,
  input  wire logic [W_P2-1:0]  p2_alt_val,
  output logic      [3:0]       intp_req,
  input  wire logic [W_P4-1:0]  p4_i,
  output logic      [W_P4-1:0]  p4_o,
  output logic      [W_P4-1:0]  p4_oe,
  output logic      [W_P4-1:0]  p4_pu,
  input  wire logic [W_P5-1:0]  p5_i,
  output logic      [W_P5-1:0]  p5_o,
  output logic      [W_P5-1:0]  p5_oe,
  output logic      [W_P5-1:0]  p5_pu,
  input  wire logic [W_P6-1:0]  p6_i,
  input  wire logic [W_P8-1:0]  p8_i,
  output logic      [W_P8-1:0]  p8_o,
  output logic      [W_P8-1:0]  p8_oe,
  output logic      [W_P8-1:0]  p8_pu,
  input  wire logic [W_P9-1:0]  p9_i,
  output logic      [W_P9-1:0]  p9_o,
  output logic      [W_P9-1:0]  p9_oe,
  output logic      [W_P9-1:0]  p9_pu
);

  logic [1:0]      rst_sync_q;
  logic            rst_n_q;
  logic            rd_take;
  logic            wr_commit;
  logic            wr_ok;
  logic [6:0]      adr;
  logic [7:0]      wbyte;
  logic [7:0]      rd_byte;
  logic [7:0]      pu0_q;
  logic [7:0]      pu1_q;
  logic [7:0]      pu2_q;
  logic            cmp_od_q;
  logic [3:0]      intp_prev_q;
  logic            intp_arm_q;
  logic [W_P0-1:0] p0_lat, p0_dir, p0_rd;
  logic [W_P2-1:0] p2_lat, p2_dir, p2_rd;
  logic [W_P4-1:0] p4_lat, p4_dir, p4_rd;
  logic [W_P5-1:0] p5_lat, p5_dir, p5_rd;
  logic [W_P8-1:0] p8_lat, p8_dir, p8_rd;
  logic [W_P9-1:0] p9_lat, p9_dir, p9_rd;
  logic [7:0]      p8_pull;
  logic [7:0]      p9_pull;

  // Two-flop reset release; the rest of the design uses this copy
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n_q = rst_sync_q[1];

  mdp_bus u_bus (
    .clock       (clock),
    .rst_n       (rst_n_q),
    .read        (read),
    .write       (write),
    .waitrequest (waitrequest),
    .rd_take     (rd_take),
    .wr_commit   (wr_commit)
  );

  // Only lane 0 carries data; other lanes alone write nothing
  assign adr   = {address[6:2], 2'b00};
  assign wbyte = writedata[7:0];
  assign wr_ok = wr_commit && byteenable[0];

  // Pull-up control words
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pu0_q    <= PU_RST;
      pu1_q    <= PU_RST;
      pu2_q    <= PU_RST;
      cmp_od_q <= 1'b0;
    end
    else if (wr_ok)
    begin
      if (adr == ADR_PU0)
        pu0_q <= wbyte & PU0_MASK;
      if (adr == ADR_PU1)
        pu1_q <= wbyte;
      if (adr == ADR_PU2)
        pu2_q <= wbyte & PU2_MASK;
      if (adr == ADR_CMP)
        cmp_od_q <= wbyte[CMP_OD_BIT];
    end
  end

  // Pairs of pins share one bit on ports 8 and 9
  assign p8_pull = mdp_pair(pu2_q[PU2_P8_LSB +: 4]);
  assign p9_pull = mdp_pair({2'b00, pu2_q[PU2_P9_LSB +: 2]});

  // Port 0: one group pull-up bit
  mdp_port #(.W(W_P0), .OPEN_DRAIN(1'b0)) u_p0 (
    .clock    (clock),
    .rst_n    (rst_n_q),
    .wr_lat   (wr_ok && adr == ADR_P0),
    .wr_dir   (wr_ok && adr == ADR_PM0),
    .wdata    (wbyte[W_P0-1:0]),
    .pin_i    (p0_i),
    .alt_sel  ('0),
    .alt_val  ('0),
    .od_sel   ('0),
    .pull_req ({W_P0{pu0_q[PU0_P0_BIT]}}),
    .lat_q    (p0_lat),
    .dir_q    (p0_dir),
    .rd_val   (p0_rd),
    .pad_o    (p0_o),
    .pad_oe   (p0_oe),
    .pad_pu   (p0_pu)
  );

  // Port 2: per-pin pull-ups, shared functions, comparator open drain
  mdp_port #(.W(W_P2), .OPEN_DRAIN(1'b0)) u_p2 (
    .clock    (clock),
    .rst_n    (rst_n_q),
    .wr_lat   (wr_ok && adr == ADR_P2),
    .wr_dir   (wr_ok && adr == ADR_PM2),
    .wdata    (wbyte),
    .pin_i    (p2_i),
    .alt_sel  (p2_alt_sel),
    .alt_val  (p2_alt_val),
    .od_sel   ({4'h0, cmp_od_q, 3'h0}),
    .pull_req (pu1_q),
    .lat_q    (p2_lat),
    .dir_q    (p2_dir),
    .rd_val   (p2_rd),
    .pad_o    (p2_o),
    .pad_oe   (p2_oe),
    .pad_pu   (p2_pu)
  );

  // Port 4: one group pull-up bit for all eight
  mdp_port #(.W(W_P4), .OPEN_DRAIN(1'b0)) u_p4 (
    .clock    (clock),
    .rst_n    (rst_n_q),
    .wr_lat   (wr_ok && adr == ADR_P4),
    .wr_dir   (wr_ok && adr == ADR_PM4),
    .wdata    (wbyte),
    .pin_i    (p4_i),
    .alt_sel  ('0),
    .alt_val  ('0),
    .od_sel   ('0),
    .pull_req ({W_P4{pu0_q[PU0_P4_BIT]}}),
    .lat_q    (p4_lat),
    .dir_q    (p4_dir),
    .rd_val   (p4_rd),
    .pad_o    (p4_o),
    .pad_oe   (p4_oe),
    .pad_pu   (p4_pu)
  );

  // Port 5: open drain; pull-up fixed at build, none in flash build
  mdp_port #(.W(W_P5), .OPEN_DRAIN(1'b1)) u_p5 (
    .clock    (clock),
    .rst_n    (rst_n_q),
    .wr_lat   (wr_ok && adr == ADR_P5),
    .wr_dir   (wr_ok && adr == ADR_PM5),
    .wdata    (wbyte[W_P5-1:0]),
    .pin_i    (p5_i),
    .alt_sel  ('0),
    .alt_val  ('0),
    .od_sel   ('0),
    .pull_req (FLASH_BUILD ? 4'h0 : P5_MASK_PU),
    .lat_q    (p5_lat),
    .dir_q    (p5_dir),
    .rd_val   (p5_rd),
    .pad_o    (p5_o),
    .pad_oe   (p5_oe),
    .pad_pu   (p5_pu)
  );

  // Port 8: pull-ups in pairs
  mdp_port #(.W(W_P8), .OPEN_DRAIN(1'b0)) u_p8 (
    .clock    (clock),
    .rst_n    (rst_n_q),
    .wr_lat   (wr_ok && adr == ADR_P8),
    .wr_dir   (wr_ok && adr == ADR_PM8),
    .wdata    (wbyte),
    .pin_i    (p8_i),
    .alt_sel  ('0),
    .alt_val  ('0),
    .od_sel   ('0),
    .pull_req (p8_pull),
    .lat_q    (p8_lat),
    .dir_q    (p8_dir),
    .rd_val   (p8_rd),
    .pad_o    (p8_o),
    .pad_oe   (p8_oe),
    .pad_pu   (p8_pu)
  );

  // Port 9: pull-ups in pairs
  mdp_port #(.W(W_P9), .OPEN_DRAIN(1'b0)) u_p9 (
    .clock    (clock),
    .rst_n    (rst_n_q),
    .wr_lat   (wr_ok && adr == ADR_P9),
    .wr_dir   (wr_ok && adr == ADR_PM9),
    .wdata    (wbyte[W_P9-1:0]),
    .pin_i    (p9_i),
    .alt_sel  ('0),
    .alt_val  ('0),
    .od_sel   ('0),
    .pull_req (p9_pull[W_P9-1:0]),
    .lat_q    (p9_lat),
    .dir_q    (p9_dir),
    .rd_val   (p9_rd),
    .pad_o    (p9_o),
    .pad_oe   (p9_oe),
    .pad_pu   (p9_pu)
  );

  // Read mux; port 6 is input only, unmapped reads give zero
  always_comb
  begin
    case (adr)
      ADR_P0:  rd_byte = {4'h0, p0_rd};
      ADR_P2:  rd_byte = p2_rd;
      ADR_P4:  rd_byte = p4_rd;
      ADR_P5:  rd_byte = {4'h0, p5_rd};
      ADR_P6:  rd_byte = {1'b0, p6_i};
      ADR_P8:  rd_byte = p8_rd;
      ADR_P9:  rd_byte = {4'h0, p9_rd};
      ADR_PM0: rd_byte = {4'hf, p0_dir};
      ADR_PM2: rd_byte = p2_dir;
      ADR_PM4: rd_byte = p4_dir;
      ADR_PM5: rd_byte = {4'hf, p5_dir};
      ADR_PM8: rd_byte = p8_dir;
      ADR_PM9: rd_byte = {4'hf, p9_dir};
      ADR_PU0: rd_byte = pu0_q;
      ADR_PU1: rd_byte = pu1_q;
      ADR_PU2: rd_byte = pu2_q;
      ADR_CMP: rd_byte = {6'h00, cmp_od_q, 1'b0};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read data captured as the request is seen, held until the next read
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
      readdata <= 32'h0000_0000;
    else if (rd_take)
      readdata <= {24'h00_0000, rd_byte};
  end

  // Edge on an interrupt pin, driven or not, raises a one-cycle request
  // Held off one cycle after reset: a pin idling high is not an edge
  always_ff @(posedge clock or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      intp_arm_q  <= 1'b0;
      intp_prev_q <= 4'h0;
      intp_req    <= 4'h0;
    end
    else
    begin
      intp_arm_q  <= 1'b1;
      intp_prev_q <= p2_i[7:4];
      intp_req    <= intp_arm_q ? (p2_i[7:4] ^ intp_prev_q)
                                : 4'h0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n_q);

  sequence s_p0_write;
    wr_ok && (adr == ADR_P0);
  endsequence

  sequence s_p0_landed;
    (p0_lat == $past(writedata[3:0])) ##1 (p0_o == $past(p0_lat));
  endsequence

  property p_rst_dir;
    $rose(rst_n_q) |-> (p2_dir == DIR_RST) && (p0_oe == 4'h0);
  endproperty
  a_rst_dir: assert property (p_rst_dir)
    else $error("direction not input after reset");

  property p_p0_write;
    s_p0_write |=> s_p0_landed;
  endproperty
  a_p0_write: assert property (p_p0_write)
    else $error("port 0 latch write not reflected");

  property p_p0_dir;
    (p0_oe & $past(p0_dir)) == 4'h0;
  endproperty
  a_p0_dir: assert property (p_p0_dir)
    else $error("port 0 drives an input pin");

  property p_p2_dir;
    (p2_oe & $past(p2_dir)) == 8'h00;
  endproperty
  a_p2_dir: assert property (p_p2_dir)
    else $error("port 2 drives an input pin");

  property p_pu0;
    p0_pu == ($past({4{pu0_q[PU0_P0_BIT]}}) & $past(p0_dir));
  endproperty
  a_pu0: assert property (p_pu0)
    else $error("port 0 group pull-up wrong");

  property p_pu1;
    p2_pu == $past(pu1_q & p2_dir);
  endproperty
  a_pu1: assert property (p_pu1)
    else $error("port 2 pull-up wrong");

  property p_p5_od;
    (p5_o == 4'h0) && ((p5_oe & $past(p5_lat | p5_dir)) == 4'h0);
  endproperty
  a_p5_od: assert property (p_p5_od)
    else $error("port 5 drives high or drives an input");

  property p_cmp_od;
    cmp_od_q && !p2_dir[3] && !p2_alt_sel[3] && p2_lat[3]
      |=> !p2_oe[3] && !p2_o[3];
  endproperty
  a_cmp_od: assert property (p_cmp_od)
    else $error("comparator pin not open drain");

  property p_intp;
    intp_arm_q && (p2_i[4] != $past(p2_i[4])) |=> intp_req[0];
  endproperty
  a_intp: assert property (p_intp)
    else $error("interrupt pin edge missed");

  property p_wait;
    (read || write) |-> ##[0:1] !waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus access not answered");

endmodule

// File: tb/mdp_pin_model.sv
// Board side of one port: each wire's level from block and board drive.
// Assumes one clock; pads are registered by the block.
module mdp_pin_model
#(
  parameter int W = 8
)
(
  input  wire logic         clock,
  input  wire logic [W-1:0] pad_o,
  input  wire logic [W-1:0] pad_oe,
  input  wire logic [W-1:0] pad_pu,
  input  wire logic [W-1:0] ext_en,
  input  wire logic [W-1:0] ext_v,
  output logic      [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W-1:0] float_q = '0;

  // A floating wire wanders every cycle, so a stale level never passes
  always_ff @(posedge clock)
    float_q <= ~float_q;

  // Block drive first, then the board driver, then the pull-up
  always_comb
    for (int i = 0; i < W; i++)
      pin[i] = pad_oe[i] ? pad_o[i] : ext_en[i] ? ext_v[i] :
               pad_pu[i] ? 1'b1 : float_q[i];
endmodule

// File: tb/test_mdp_top.sv
// Self-checking bench for the port bank: Avalon-MM master, pin models.
// Assumes the block answers each access with one waitrequest-low cycle.
module test_mdp_top
  import mdp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] LA [6] = '{ADR_P0, ADR_P2, ADR_P4, ADR_P5,
                                   ADR_P8, ADR_P9};
  localparam logic [6:0] DA [6] = '{ADR_PM0, ADR_PM2, ADR_PM4, ADR_PM5,
                                   ADR_PM8, ADR_PM9};
  localparam logic [7:0] WM [6] = '{8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff,
                                   8'h0f};
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic [6:0]  address = 7'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [3:0]  byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  p2_alt_sel = 8'h00;
  logic [7:0]  p2_alt_val = 8'h00;
  logic [6:0]  p6_i = 7'h00;
  logic [3:0]  intp_req;
  logic [3:0]  p0_o, p0_oe, p0_pu, p5_o, p5_oe, p5_pu, p9_o, p9_oe, p9_pu;
  logic [7:0]  p2_o, p2_oe, p2_pu, p4_o, p4_oe, p4_pu, p8_o, p8_oe, p8_pu;
  logic [3:0]  pin0, pin5, pin9;
  logic [7:0]  pin2, pin4, pin8;
  logic [7:0]  xen [6] = '{default: 8'h00};
  logic [7:0]  xv [6] = '{default: 8'h00};
  logic [7:0]  oe_a [6];
  logic [7:0]  o_a [6];
  logic [7:0]  pu_a [6];
  logic [7:0]  dsav [6];
  logic [7:0]  lfsr_q = 8'h39;
  int          icnt [4] = '{default: 0};
  int          n_mismatch = 0;
  int          n_compared = 0;

  // Output groups gathered per port, same order as the address tables
  assign oe_a = '{{4'h0, p0_oe}, p2_oe, p4_oe, {4'h0, p5_oe}, p8_oe,
                  {4'h0, p9_oe}};
  assign o_a  = '{{4'h0, p0_o}, p2_o, p4_o, {4'h0, p5_o}, p8_o,
                  {4'h0, p9_o}};
  assign pu_a = '{{4'h0, p0_pu}, p2_pu, p4_pu, {4'h0, p5_pu}, p8_pu,
                  {4'h0, p9_pu}};

  always #20 clock = ~clock;

  // Counts request pulses so each pin edge can be checked as one
  always @(posedge clock)
    for (int i = 0; i < 4; i++)
      if (intp_req[i] === 1'b1)
        icnt[i]++;

  mdp_top #(
    .FLASH_BUILD (1'b0),
    .P5_MASK_PU  (4'ha)
  ) u_mdp_top (
    .clock (clock), .rst_b (rst_b), .address (address), .read (read),
    .write (write), .byteenable (byteenable), .writedata (writedata),
    .readdata (readdata), .waitrequest (waitrequest),
    .p0_i (pin0), .p0_o (p0_o), .p0_oe (p0_oe), .p0_pu (p0_pu),
    .p2_i (pin2), .p2_o (p2_o), .p2_oe (p2_oe), .p2_pu (p2_pu),
    .p2_alt_sel (p2_alt_sel), .p2_alt_val (p2_alt_val),
    .intp_req (intp_req),
    .p4_i (pin4), .p4_o (p4_o), .p4_oe (p4_oe), .p4_pu (p4_pu),
    .p5_i (pin5), .p5_o (p5_o), .p5_oe (p5_oe), .p5_pu (p5_pu),
    .p6_i (p6_i),
    .p8_i (pin8), .p8_o (p8_o), .p8_oe (p8_oe), .p8_pu (p8_pu),
    .p9_i (pin9), .p9_o (p9_o), .p9_oe (p9_oe), .p9_pu (p9_pu)
  );
  mdp_pin_model #(.W (W_P0)) u_mdp_pin_model_0 (.clock (clock),
    .pad_o (p0_o), .pad_oe (p0_oe), .pad_pu (p0_pu), .ext_en (xen[0][3:0]),
    .ext_v (xv[0][3:0]), .pin (pin0));
  mdp_pin_model #(.W (W_P2)) u_mdp_pin_model_2 (.clock (clock),
    .pad_o (p2_o), .pad_oe (p2_oe), .pad_pu (p2_pu), .ext_en (xen[1]),
    .ext_v (xv[1]), .pin (pin2));
  mdp_pin_model #(.W (W_P4)) u_mdp_pin_model_4 (.clock (clock),
    .pad_o (p4_o), .pad_oe (p4_oe), .pad_pu (p4_pu), .ext_en (xen[2]),
    .ext_v (xv[2]), .pin (pin4));
  mdp_pin_model #(.W (W_P5)) u_mdp_pin_model_5 (.clock (clock),
    .pad_o (p5_o), .pad_oe (p5_oe), .pad_pu (p5_pu), .ext_en (xen[3][3:0]),
    .ext_v (xv[3][3:0]), .pin (pin5));
  mdp_pin_model #(.W (W_P8)) u_mdp_pin_model_8 (.clock (clock),
    .pad_o (p8_o), .pad_oe (p8_oe), .pad_pu (p8_pu), .ext_en (xen[4]),
    .ext_v (xv[4]), .pin (pin8));
  mdp_pin_model #(.W (W_P9)) u_mdp_pin_model_9 (.clock (clock),
    .pad_o (p9_o), .pad_oe (p9_oe), .pad_pu (p9_pu), .ext_en (xen[5][3:0]),
    .ext_v (xv[5][3:0]), .pin (pin9));

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic roll(output logic [7:0] r);
    lfsr_q = lfsr_next(lfsr_q);
    r = lfsr_q;
  endtask

  // One pull-up bit widened onto a pin pair
  function automatic logic [7:0] pairs(input logic [3:0] c);
    logic [7:0] r;
    for (int i = 0; i < 4; i++)
      r[2*i+:2] = {2{c[i]}};
    return r;
  endfunction

  // Request held until waitrequest is sampled low; data taken there
  task automatic bus(input logic wr, input logic [6:0] a,
                     input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clock);
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    check("bus_answer", {7'h0, waitrequest}, 8'h00);
    if (!wr)
      check("rd_hi", {7'h0, |readdata[31:8]}, 8'h00);
    q = readdata[7:0];
    write <= 1'b0;
    read <= 1'b0;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp,
                    input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, 4'hf, q);
    check(nm, q, exp);
  endtask

  // Watchdog: the tests need a few thousand cycles at most
  initial
  begin
    #800000;
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    logic [7:0] d, l, e, u0, u1, u2;
    int         c0 [4];
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    // Reset state of every port
    for (int k = 0; k < 6; k++)
    begin
      check("oe", oe_a[k], 8'h00);
      rd(DA[k], 8'hff, "dir_rst");
    end
    // Random direction, latch and board levels; all-out and all-in first
    for (int it = 0; it < 12; it++)
      for (int k = 0; k < 6; k++)
      begin
        roll(d);
        roll(l);
        roll(e);
        d = (it == 0) ? 8'h00 : (it == 1) ? 8'hff : d;
        dsav[k] = d;
        xen[k] <= 8'hff;
        xv[k] <= e;
        wr(LA[k], l);
        wr(DA[k], d);
        repeat (2) @(posedge clock);
        if (k == 3)
        begin
          check("od_oe", oe_a[k], ~d & ~l & WM[k]);
          check("od_o", o_a[k] & WM[k], 8'h00);
        end
        else
        begin
          check("oe", oe_a[k], ~d & WM[k]);
          check("o", o_a[k] & ~d, l & ~d & WM[k]);
        end
        rd(DA[k], d | ~WM[k], "dir");
        rd(LA[k], ((l & ~d) | (e & d)) & WM[k], "port");
      end
    // Pull-up groups with random directions, boards released
    for (int it = 0; it < 8; it++)
    begin
      for (int k = 0; k < 6; k++)
      begin
        roll(d);
        dsav[k] = d;
        xen[k] <= 8'h00;
        wr(DA[k], d);
      end
      roll(u0);
      roll(u1);
      roll(u2);
      wr(ADR_PU0, u0);
      wr(ADR_PU1, u1);
      wr(ADR_PU2, u2);
      repeat (2) @(posedge clock);
      check("pu0", pu_a[0], {8{u0[0]}} & dsav[0] & 8'h0f);
      check("pu2", pu_a[1], u1 & dsav[1]);
      check("pu4", pu_a[2], {8{u0[4]}} & dsav[2]);
      check("pu5", pu_a[3], 8'h0a & dsav[3]);
      check("pu8", pu_a[4], pairs(u2[3:0]) & dsav[4]);
      check("pu9", pu_a[5], pairs({2'b0, u2[5:4]}) & dsav[5]);
      rd(ADR_PU0, u0 & PU0_MASK, "pu0_reg");
      rd(ADR_PU2, u2 & PU2_MASK, "pu2_reg");
    end
    // Disabled lane leaves the register alone
    bus(1'b1, ADR_PM0, 8'h00, 4'he, l);
    rd(ADR_PM0, dsav[0] | 8'hf0, "be_off");
    // Input-only port and unmapped places
    roll(e);
    p6_i <= e[6:0];
    rd(ADR_P6, e & 8'h7f, "port6");
    wr(7'h3c, 8'h5a);
    rd(7'h3c, 8'h00, "unmapped");
    // Direction and latch set before the peripheral takes pin 0
    wr(LA[1], 8'h08);
    wr(DA[1], 8'h00);
    p2_alt_sel <= 8'h01;
    p2_alt_val <= 8'h01;
    wr(ADR_CMP, 8'h02);
    repeat (2) @(posedge clock);
    check("alt", {7'h0, p2_o[0]}, 8'h01);
    check("cmp_oe_hi", {7'h0, p2_oe[3]}, 8'h00);
    wr(LA[1], 8'h00);
    repeat (2) @(posedge clock);
    check("cmp_oe_lo", {p2_o[3], p2_oe[3]}, 8'h01);
    wr(ADR_CMP, 8'h00);
    wr(LA[1], 8'h08);
    repeat (2) @(posedge clock);
    check("cmp_push", {p2_o[3], p2_oe[3]}, 8'h03);
    // Edges on the request pins, first as inputs then as outputs
    p2_alt_sel <= 8'h00;
    xen[1] <= 8'hff;
    xv[1] <= 8'h00;
    wr(DA[1], 8'hff);
    repeat (4) @(posedge clock);
    c0 = icnt;
    for (int j = 4; j < 8; j++)
    begin
      xv[1][j] <= 1'b1;
      repeat (5) @(posedge clock);
    end
    for (int j = 0; j < 4; j++)
      check("intp_in", 8'(icnt[j] - c0[j]), 8'h01);
    wr(LA[1], 8'hf0);
    wr(DA[1], 8'h0f);
    repeat (4) @(posedge clock);
    c0 = icnt;
    wr(LA[1], 8'h00);
    repeat (5) @(posedge clock);
    for (int j = 0; j < 4; j++)
      check("intp_out", 8'(icnt[j] - c0[j]), 8'h01);
    give_verdict();
  end
endmodule
